// ==== src/ila_cfg.svh ====
// constants for the interrupt latch and arbitration block
`ifndef ILA_CFG_SVH
`define ILA_CFG_SVH

// ****************************************
// source count and condition code layout
// ****************************************
`define ILA_NUM_SRC 6
`define ILA_CODE_W 3
`define ILA_CCR_I_BIT 3
`define ILA_RESET_I_MASK 1'b1

// ****************************************
// vector high-byte addresses, priority order
// ****************************************
`define ILA_VEC_IRQ 16'hFFFA
`define ILA_VEC_CH0 16'hFFF6
`define ILA_VEC_CH1 16'hFFF4
`define ILA_VEC_TOF 16'hFFF2
`define ILA_VEC_KBI 16'hFFE0
`define ILA_VEC_ADC 16'hFFDE

// ****************************************
// stack frame
// ****************************************
`define ILA_FRAME_BYTES 3'h5
`define ILA_LAST_STEP 3'h4

`endif

// ==== src/ila_pkg.sv ====
// types and shared functions of the interrupt latch and arbitration block
`include "ila_cfg.svh"

package ila_pkg;

	typedef logic [`ILA_CODE_W-1:0] ila_code_t;

	typedef enum logic [2:0] {
		ST_RUN,
		ST_PUSH,
		ST_VEC_H,
		ST_VEC_L,
		ST_LOAD,
		ST_POP,
		ST_RESUME
	} ila_state_e;

	// lowest set index wins; index 0 is the highest priority source
	function automatic ila_code_t ilaPriCode(input logic [`ILA_NUM_SRC-1:0] pend);
		ila_code_t code;
		code = '0;
		for (int i = `ILA_NUM_SRC - 1; i >= 0; i--) begin
			if (pend[i]) begin
				code = ila_code_t'(i);
			end
		end
		return code;
	endfunction

	// code to vector high-byte address
	function automatic logic [15:0] ilaVecAddr(input ila_code_t code);
		logic [15:0] addr;
		addr = `ILA_VEC_ADC;
		unique case (code)
			3'h0: addr = `ILA_VEC_IRQ;
			3'h1: addr = `ILA_VEC_CH0;
			3'h2: addr = `ILA_VEC_CH1;
			3'h3: addr = `ILA_VEC_TOF;
			3'h4: addr = `ILA_VEC_KBI;
			default: addr = `ILA_VEC_ADC;
		endcase
		return addr;
	endfunction

endpackage

// ==== src/ila_arb_if.sv ====
// carrier between the entry sequencer and the request latch
`timescale 1ns/10ps
`include "ila_cfg.svh"
interface ila_arb_if;
	import ila_pkg::*;

	logic capture;
	logic drop;
	logic [`ILA_NUM_SRC-1:0] eligible;
	logic latched;
	ila_code_t code;

	modport sequencer (output capture, output drop, output eligible, input latched,
		input code);
	modport arbiter (input capture, input drop, input eligible, output latched,
		output code);
endinterface

// ==== src/ila_latch_arbiter.sv ====
// request latch with fixed-priority arbitration
`timescale 1ns/10ps
`include "ila_cfg.svh"
module ila_latch_arbiter
	import ila_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	ila_arb_if.arbiter arb
);

	logic [`ILA_NUM_SRC-1:0] pend_q;
	logic latched_q;
	ila_code_t code_q;

	// ****************************************
	// latch and arbitrate
	// ****************************************
	// latch at capture only
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pend_q <= '0;
			latched_q <= 1'b0;
			code_q <= '0;
		end else if (arb.drop) begin
			pend_q <= '0;
			latched_q <= 1'b0;
		end else if (arb.capture && !latched_q && |arb.eligible) begin
			pend_q <= arb.eligible;
			latched_q <= 1'b1;
			code_q <= ilaPriCode(arb.eligible);
		end
	end

	assign arb.latched = latched_q;
	assign arb.code = code_q;

	// ****************************************
	// checks
	// ****************************************
	latch_frozen_a: assert property (@(posedge clock) disable iff (!rst_n)
		latched_q && !arb.drop |=> $stable(code_q) && latched_q)
		else $error("latched code displaced before release");
	pick_highest_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(latched_q) |-> pend_q[code_q] && ((pend_q & ((6'h01 << code_q) - 6'h01)) == '0))
		else $error("arbitration did not pick highest priority");

endmodule // ila_latch_arbiter

// ==== src/ila_int_sequencer.sv ====
// interrupt entry and return sequencer of the system integration unit
// ****************************************
// Overview of operation
// - Requests latched and arbitrated only when interrupt processing starts.
// - Arbitration result given to the core as a code selecting vector pair.
// - A latched interrupt stays until serviced or global mask cleared.
// - Entry pushes CPU registers onto the stack before vector fetch.
// - Entry sets the global interrupt mask bit.
// - Return instruction pops saved registers and resumes interrupted flow.
// - Requests examined only after the current instruction completes.
// - Service only with mask clear and source enable set.
// - Highest fixed priority pending request is serviced first.
// - High index byte is never stacked on entry.
// ****************************************
`timescale 1ns/10ps
`include "ila_cfg.svh"
module ila_int_sequencer
	import ila_pkg::*;
(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [`ILA_NUM_SRC-1:0] irqReq,
	input wire logic [`ILA_NUM_SRC-1:0] irqEn,
	input wire logic instrDone,
	input wire logic rtiExec,
	input wire logic maskWrite,
	input wire logic maskValue,
	input wire logic [15:0] pcIn,
	input wire logic [15:0] spIn,
	input wire logic [7:0] accIn,
	input wire logic [7:0] xIn,
	input wire logic [7:0] ccrIn,
	input wire logic [7:0] memRdData,
	output logic [15:0] memAddr,
	output logic [7:0] memWrData,
	output logic memWr,
	output logic memRd,
	output logic cpuHold,
	output logic iMask,
	output ila_code_t vecCode,
	output logic vecValid,
	output logic pcLoad,
	output logic [15:0] pcOut,
	output logic ctxLoad,
	output logic [15:0] spOut,
	output logic [7:0] accOut,
	output logic [7:0] xOut,
	output logic [7:0] ccrOut
);

	ila_arb_if arb ();

	ila_latch_arbiter u_arb (
		.clock(clock),
		.rst_n(rst_n),
		.arb(arb.arbiter)
	);

	ila_state_e state_q;
	logic [2:0] step_q;
	logic [15:0] sp_q;
	logic [15:0] addr_q;
	logic [7:0] wdata_q;
	logic wr_q;
	logic rd_q;
	logic iMask_q;
	logic [7:0] pcHi_q;
	logic pcLoad_q;
	logic ctxLoad_q;
	logic [15:0] pc_q;
	logic [7:0] acc_q;
	logic [7:0] x_q;
	logic [7:0] ccr_q;
	logic [7:0] stackByte;
	logic takeIrq;

	// ****************************************
	// recognition
	// ****************************************
	// mask and enable gate requests
	assign arb.eligible = (iMask_q || maskWrite) ? '0 : (irqReq & irqEn);
	assign arb.capture = instrDone && (state_q == ST_RUN);
	assign takeIrq = arb.latched && (state_q == ST_RUN);
	// serviced, or mask cleared by software
	assign arb.drop = (state_q == ST_LOAD) || (maskWrite && !maskValue && state_q == ST_RUN);

	// frame holds PC, X, A, CCR only
	always_comb begin
		stackByte = ccrIn;
		unique case (step_q)
			3'h0: stackByte = pcIn[7:0];
			3'h1: stackByte = pcIn[15:8];
			3'h2: stackByte = xIn;
			3'h3: stackByte = accIn;
			default: stackByte = ccrIn;
		endcase
	end

	// ****************************************
	// sequence state
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_RUN;
			step_q <= 3'h0;
		end else begin
			unique case (state_q)
				ST_RUN: begin
					step_q <= 3'h0;
					if (takeIrq) begin
						state_q <= ST_PUSH;
					end else if (rtiExec) begin
						state_q <= ST_POP;
					end
				end
				ST_PUSH: begin
					step_q <= step_q + 3'h1;
					if (step_q == `ILA_LAST_STEP) begin
						state_q <= ST_VEC_H;
					end
				end
				ST_VEC_H: state_q <= ST_VEC_L;
				ST_VEC_L: state_q <= ST_LOAD;
				ST_LOAD: state_q <= ST_RUN;
				ST_POP: begin
					step_q <= step_q + 3'h1;
					if (step_q == `ILA_FRAME_BYTES) begin
						state_q <= ST_RESUME;
					end
				end
				ST_RESUME: state_q <= ST_RUN;
			endcase
		end
	end

	// ****************************************
	// memory cycles
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			addr_q <= 16'h0000;
			wdata_q <= 8'h00;
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			sp_q <= 16'h0000;
		end else begin
			wr_q <= 1'b0;
			rd_q <= 1'b0;
			if (takeIrq) begin
				sp_q <= spIn;
			end else if (state_q == ST_RUN && rtiExec) begin
				sp_q <= spIn;
			end
			if (state_q == ST_PUSH) begin
				addr_q <= sp_q - {13'h0000, step_q};
				wdata_q <= stackByte;
				wr_q <= 1'b1;
			end else if (state_q == ST_VEC_H) begin
				addr_q <= ilaVecAddr(arb.code);
				rd_q <= 1'b1;
			end else if (state_q == ST_VEC_L) begin
				addr_q <= ilaVecAddr(arb.code) + 16'h0001;
				rd_q <= 1'b1;
			end else if (state_q == ST_POP && step_q < `ILA_FRAME_BYTES) begin
				// pop CCR, A, X, PCH, PCL
				addr_q <= sp_q + {13'h0000, step_q} + 16'h0001;
				rd_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// global mask
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			iMask_q <= `ILA_RESET_I_MASK;
		end else if (takeIrq) begin
			iMask_q <= 1'b1;
		end else if (state_q == ST_RESUME) begin
			iMask_q <= ccr_q[`ILA_CCR_I_BIT];
		end else if (maskWrite && state_q == ST_RUN) begin
			iMask_q <= maskValue;
		end
	end

	// ****************************************
	// program counter and restored context
	// ****************************************
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pcHi_q <= 8'h00;
			pc_q <= 16'h0000;
			acc_q <= 8'h00;
			x_q <= 8'h00;
			ccr_q <= 8'h00;
			pcLoad_q <= 1'b0;
			ctxLoad_q <= 1'b0;
		end else begin
			pcLoad_q <= 1'b0;
			ctxLoad_q <= 1'b0;
			if (state_q == ST_VEC_L) begin
				pcHi_q <= memRdData;
			end
			if (state_q == ST_LOAD) begin
				pc_q <= {pcHi_q, memRdData};
				pcLoad_q <= 1'b1;
			end
			if (state_q == ST_POP && step_q != 3'h0) begin
				unique case (step_q)
					3'h1: ccr_q <= memRdData;
					3'h2: acc_q <= memRdData;
					3'h3: x_q <= memRdData;
					3'h4: pc_q[15:8] <= memRdData;
					default: pc_q[7:0] <= memRdData;
				endcase
			end
			if (state_q == ST_RESUME) begin
				// hand context back to the core
				ctxLoad_q <= 1'b1;
			end
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	assign memAddr = addr_q;
	assign memWrData = wdata_q;
	assign memWr = wr_q;
	assign memRd = rd_q;
	assign cpuHold = (state_q != ST_RUN) || takeIrq;
	assign iMask = iMask_q;
	assign vecCode = arb.code;
	assign vecValid = arb.latched;
	assign pcLoad = pcLoad_q;
	assign pcOut = pc_q;
	assign ctxLoad = ctxLoad_q;
	assign spOut = ctxLoad_q ? (sp_q + {13'h0000, `ILA_FRAME_BYTES}) :
		(sp_q - {13'h0000, `ILA_FRAME_BYTES});
	assign accOut = acc_q;
	assign xOut = x_q;
	assign ccrOut = ccr_q;

	// ****************************************
	// checks
	// ****************************************
	boundary_only_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(arb.latched) |-> $past(instrDone) && $past(state_q) == ST_RUN)
		else $error("request latched away from instruction boundary");
	mask_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(arb.latched) |-> !$past(iMask_q) && ($past(irqReq & irqEn) != '0))
		else $error("request taken while masked or disabled");
	entry_mask_a: assert property (@(posedge clock) disable iff (!rst_n)
		takeIrq |=> iMask_q [*5])
		else $error("mask not set during entry");
	push_order_a: assert property (@(posedge clock) disable iff (!rst_n)
		takeIrq |=> ##1 memWr [*5] ##1 !memWr && memRd)
		else $error("five pushes must precede vector read");
	vec_addr_a: assert property (@(posedge clock) disable iff (!rst_n)
		state_q == ST_VEC_L |-> ##1 memRd && memAddr == ilaVecAddr(vecCode) + 16'h0001)
		else $error("vector low byte address wrong");
	vec_load_a: assert property (@(posedge clock) disable iff (!rst_n)
		takeIrq |-> ##9 pcLoad)
		else $error("vector not loaded nine cycles after entry");
	no_high_index_a: assert property (@(posedge clock) disable iff (!rst_n)
		memWr |-> (sp_q - memAddr) <= 16'h0004)
		else $error("entry frame wider than five bytes");
	rti_restore_a: assert property (@(posedge clock) disable iff (!rst_n)
		state_q == ST_RUN && rtiExec && !takeIrq |-> ##8 ctxLoad ##1 iMask_q == ccrOut[3])
		else $error("return did not restore context");
	code_out_a: assert property (@(posedge clock) disable iff (!rst_n)
		pcLoad |-> $past(vecCode, 2) == vecCode)
		else $error("vector code changed during fetch");

	entry_seen_c: cover property (@(posedge clock) disable iff (!rst_n) takeIrq ##9 pcLoad);
	return_seen_c: cover property (@(posedge clock) disable iff (!rst_n) ctxLoad);
	two_pending_c: cover property (@(posedge clock) disable iff (!rst_n)
		arb.capture && $countones(arb.eligible) > 1);

endmodule // ila_int_sequencer

// ==== test/ila_mem_model.sv ====
// memory partner answering stack and vector cycles
`timescale 1ns/10ps
module ila_mem_model (
	input wire logic clock,
	input wire logic [15:0] memAddr,
	input wire logic [7:0] memWrData,
	input wire logic memWr,
	input wire logic memRd,
	output logic [7:0] memRdData
);
	logic [7:0] mem [0:65535];
	logic [7:0] lastRd = 8'h5a;
	// store writes; read data stands with memRd, scrambled when not read
	always @(posedge clock) begin
		if (memWr) mem[memAddr] <= memWrData;
		lastRd <= memRdData;
	end
	assign memRdData = memRd ? mem[memAddr] : ~lastRd;
endmodule // ila_mem_model

// ==== test/interrupt_latch_arbitration_bench.sv ====
// self-checking bench of the interrupt entry and return sequencer
`timescale 1ns/10ps
`include "ila_cfg.svh"
module interrupt_latch_arbitration_bench
	import ila_pkg::*;
;
	// ****
	// stimulus and observed signals
	// ****
	logic clock = 0;
	logic rst_n = 0;
	logic [5:0] irqReq, irqEn;
	logic instrDone, rtiExec, maskWrite, maskValue;
	logic [15:0] pcIn, spIn, memAddr, pcOut, spOut;
	logic [7:0] accIn, xIn, ccrIn, memRdData, memWrData, accOut, xOut, ccrOut;
	logic memWr, memRd, cpuHold, iMask, vecValid, pcLoad, ctxLoad;
	ila_code_t vecCode;
	logic [31:0] seed = 32'h0000_3c89;
	logic [15:0] vt [6] = '{`ILA_VEC_IRQ, `ILA_VEC_CH0, `ILA_VEC_CH1,
		`ILA_VEC_TOF, `ILA_VEC_KBI, `ILA_VEC_ADC};
	int errors = 0;
	int n_compared = 0;

	// free-running clock
	always #5 clock = ~clock;

	ila_int_sequencer u_dut (.clock(clock), .rst_n(rst_n), .irqReq(irqReq), .irqEn(irqEn),
		.instrDone(instrDone), .rtiExec(rtiExec), .maskWrite(maskWrite),
		.maskValue(maskValue), .pcIn(pcIn), .spIn(spIn), .accIn(accIn), .xIn(xIn),
		.ccrIn(ccrIn), .memRdData(memRdData), .memAddr(memAddr), .memWrData(memWrData),
		.memWr(memWr), .memRd(memRd), .cpuHold(cpuHold), .iMask(iMask), .vecCode(vecCode),
		.vecValid(vecValid), .pcLoad(pcLoad), .pcOut(pcOut), .ctxLoad(ctxLoad),
		.spOut(spOut), .accOut(accOut), .xOut(xOut), .ccrOut(ccrOut));

	ila_mem_model u_mem (.clock(clock), .memAddr(memAddr), .memWrData(memWrData),
		.memWr(memWr), .memRd(memRd), .memRdData(memRdData));

	// ****
	// helpers
	// ****
	function automatic logic [31:0] nxt();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic unmask();
		@(posedge clock);
		maskWrite <= 1;
		maskValue <= 0;
		@(posedge clock);
		maskWrite <= 0;
	endtask

	// request presented but must not be taken
	task automatic idle(input logic [5:0] req, input logic [5:0] en, input logic done);
		@(posedge clock);
		irqReq <= req;
		irqEn <= en;
		instrDone <= done;
		@(negedge clock);
		chk(cpuHold, 0, "hold on refused request");
		@(posedge clock);
		instrDone <= 0;
		@(negedge clock);
		chk(vecValid, 0, "code on refused request");
		chk(cpuHold, 0, "hold after refused request");
	endtask

	// entry, vector load and return, checked against a queue model
	task automatic service(input logic [5:0] req, input logic [5:0] en);
		logic [23:0] wq [$];
		logic [15:0] sp, pc;
		logic [7:0] a, x, c;
		int code, n;
		sp = nxt();
		pc = nxt();
		a = nxt();
		x = nxt();
		c = nxt();
		code = 0;
		for (int i = 5; i >= 0; i--) if (req[i] & en[i]) code = i;
		wq = '{{sp, pc[7:0]}, {sp - 16'h1, pc[15:8]}, {sp - 16'h2, x}, {sp - 16'h3, a},
			{sp - 16'h4, c}};
		@(posedge clock);
		irqReq <= req;
		irqEn <= en;
		instrDone <= 1;
		spIn <= sp;
		pcIn <= pc;
		accIn <= a;
		xIn <= x;
		ccrIn <= c;
		@(posedge clock);
		instrDone <= 0;
		irqReq <= 6'h3f;
		for (n = 0; n < 20; n++) begin
			@(negedge clock);
			if (memWr === 1'b1) begin
				chk(memAddr, wq[0][23:8], "push address");
				chk(memWrData, wq[0][7:0], "push data");
				chk(cpuHold, 1, "hold during entry");
				wq.pop_front();
			end
			if (vecValid === 1'b1) chk(vecCode, code, "arbitration code");
			if (pcLoad === 1'b1) break;
		end
		if (n == 20) begin
			errors++;
			close_out();
		end
		chk(pcOut, {u_mem.mem[vt[code]], u_mem.mem[vt[code] + 16'h1]}, "vector");
		chk(wq.size(), 0, "frame size");
		chk(iMask, 1, "mask set on entry");
		chk(spOut, sp - 16'h5, "stack after entry");
		idle(6'h3f, 6'h3f, 1);
		@(posedge clock);
		rtiExec <= 1;
		spIn <= sp - 16'h5;
		@(posedge clock);
		rtiExec <= 0;
		for (n = 0; n < 20; n++) begin
			@(negedge clock);
			if (ctxLoad === 1'b1) break;
		end
		if (n == 20) begin
			errors++;
			close_out();
		end
		chk(pcOut, pc, "restored pc");
		chk({accOut, xOut}, {a, x}, "restored a x");
		chk(ccrOut, c, "restored ccr");
		chk(spOut, sp, "stack after return");
		@(negedge clock);
		chk(iMask, c[3], "mask restored");
	endtask

	// ****
	// main sequence
	// ****
	initial begin
		logic [31:0] r;
		logic [5:0] req, en;
		{irqReq, irqEn, instrDone, rtiExec, maskWrite, maskValue} = '0;
		{pcIn, spIn, accIn, xIn, ccrIn} = '0;
		for (int i = 0; i < 6; i++) begin
			u_mem.mem[vt[i]] = nxt();
			u_mem.mem[vt[i] + 16'h1] = nxt();
		end
		repeat (2) @(posedge clock);
		rst_n <= 1;
		@(negedge clock);
		chk(iMask, 1, "mask after reset");
		idle(6'h3f, 6'h3f, 1);
		for (int t = 0; t < 14; t++) begin
			r = nxt();
			req = r[5:0] | 6'h20;
			en = r[11:6] | 6'h20;
			if (t < 6) begin
				req = (r[5:0] | (6'h1 << t)) & (6'h3f << t);
				en = r[11:6] | (6'h1 << t);
			end
			unmask();
			idle(6'h3f, 6'h3f, 0);
			idle(req, ~req, 1);
			service(req, en);
			$display("test %0d done", t);
		end
		close_out();
	end
endmodule // interrupt_latch_arbitration_bench
